// File: verilog/tsigc_pkg.sv
// Constants, types and register map of the global control and self-test block
package tsigc_pkg;

	// Bus geometry
	localparam int ADDR_W = 15;
	localparam int DATA_W = 8;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] REG_GEN_CMD      = 15'h0000;
	localparam logic [ADDR_W-1:0] REG_SOFT_RST     = 15'h0001;
	localparam logic [ADDR_W-1:0] REG_BIST_CMD     = 15'h0002;
	localparam logic [ADDR_W-1:0] REG_GLB_IRQ_MASK = 15'h0006;
	localparam logic [ADDR_W-1:0] REG_IRQ_STATUS   = 15'h0007;
	localparam logic [ADDR_W-1:0] REG_IRQ_MASK     = 15'h0008;

	// Field positions
	localparam int GC_GXE   = 0;
	localparam int GC_FRAME_SYNC_SAMPLE_EDGE  = 1;
	localparam int GC_FSP   = 2;
	localparam int GC_INTERRUPT_POLARITY_SELECT  = 3;
	localparam int GC_INTERRUPT_OUTPUT_DRIVE_ENABLE = 4;
	localparam int SR_BIT   = 0;
	localparam int BC_FAIL  = 5;
	localparam int BC_DONE  = 6;
	localparam int BC_RUN   = 7;
	localparam int GIE_BIT  = 0;
	localparam int IRQ_BC   = 1;

	// Reset value of every register byte
	localparam logic [DATA_W-1:0] REG_RST  = 8'h00;
	localparam logic [DATA_W-1:0] REG_ZERO = 8'h00;

	// Timing
	localparam int  CLK_PERIOD_NS   = 8;
	localparam real BIST_TIME_S     = 2.8;
	localparam longint BIST_CYCLES  = longint'(BIST_TIME_S * 1.0e9 / real'(CLK_PERIOD_NS));
	localparam int  NUM_HIGHWAYS    = 32;

	// Lower fields of the general command register
	typedef struct packed {
		logic interrupt_output_drive_enable;
		logic interrupt_polarity_select;
		logic frame_sync_polarity;
		logic frame_sync_sample_edge;
		logic global_transmit_enable;
	} tsigc_gen_cmd_t;

	// Request captured from the host bus
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} tsigc_bus_req_t;

	// Self-test result as seen by software
	typedef struct packed {
		logic done;
		logic fail;
	} tsigc_bist_stat_t;

	// Host bus access states
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_HOLD = 2'b10
	} tsigc_bus_state_t;

	// Self-test sequencer states
	typedef enum logic [2:0] {
		BIST_IDLE = 3'b001,
		BIST_RUN  = 3'b010,
		BIST_END  = 3'b100
	} tsigc_bist_state_t;

endpackage

// File: verilog/tsigc_bist.sv
// Memory self-test sequencer: run timer, result capture and done indication
`timescale 1ns/100ps
`default_nettype none
module tsigc_bist #(
	parameter longint CYCLES = tsigc_pkg::BIST_CYCLES
) (
	input  wire logic                        i_sys_clk,
	input  wire logic                        i_nrst,
	input  wire logic                        i_start,
	input  wire logic                        i_stop,
	input  wire logic                        i_mem_error,
	output logic                             o_active,
	output logic                             o_done_pulse,
	output tsigc_pkg::tsigc_bist_stat_t      o_stat
);
	import tsigc_pkg::*;

	localparam logic [31:0] LAST = 32'(CYCLES - 1);

	tsigc_bist_state_t state;
	tsigc_bist_state_t next_state;
	logic [31:0]       count;
	logic              fail;
	wire               at_end = (count == LAST);

	// Sequencer transitions
	always_comb begin
		next_state = state;
		unique case (state)
			BIST_IDLE: if (i_start) next_state = BIST_RUN;
			BIST_RUN:  if (i_stop) next_state = BIST_IDLE;
			           else if (at_end) next_state = BIST_END;
			BIST_END:  if (i_stop) next_state = BIST_IDLE;
		endcase
	end

	// State, run timer and sticky error capture
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			state <= BIST_IDLE;
			count <= 32'h0000_0000;
			fail  <= 1'b0;
		end else begin
			state <= next_state;
			if (i_start && state == BIST_IDLE) begin
				count <= 32'h0000_0000;
				fail  <= 1'b0;
			end else if (state == BIST_RUN) begin
				count <= count + 32'h0000_0001;
				if (i_mem_error) fail <= 1'b1;
			end else if (i_stop) begin
				fail <= 1'b0;
			end
		end
	end

	// Outputs
	assign o_active     = (state == BIST_RUN);
	assign o_done_pulse = (state == BIST_RUN) && at_end && !i_stop;
	assign o_stat.done  = (state == BIST_END);
	assign o_stat.fail  = fail & (state == BIST_END);

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);

	done_holds_a: assert property (o_stat.done && !i_stop |=> o_stat.done)
		else $error("done dropped without a stop write");
	done_clear_a: assert property (o_stat.done && i_stop |=> !o_stat.done)
		else $error("done not cleared by stop write");
	run_length_a: assert property ($rose(o_stat.done) |-> $past(count) == LAST)
		else $error("self-test ended at the wrong count");
	start_fresh_a: assert property (i_start && state == BIST_IDLE |=> !o_stat.done && !fail)
		else $error("stale result after start");
endmodule
`default_nettype wire

// File: verilog/tsigc_top.sv
// Global control register bank with software reset and memory self-test control
`timescale 1ns/100ps
`default_nettype none
module tsigc_top #(
	parameter int     NUM_HW      = tsigc_pkg::NUM_HIGHWAYS,
	parameter longint BIST_CYCLES = tsigc_pkg::BIST_CYCLES
) (
	input  wire logic                        i_sys_clk,
	input  wire logic                        i_nrst,
	input  wire logic                        i_cs_n,
	input  wire logic                        i_rd_n,
	input  wire logic                        i_wr_n,
	input  wire logic [tsigc_pkg::ADDR_W-1:0] i_addr,
	input  wire logic [tsigc_pkg::DATA_W-1:0] i_data,
	output logic      [tsigc_pkg::DATA_W-1:0] o_data,
	output logic                             o_data_oe,
	output logic                             o_rdy,
	output logic                             o_irq,
	output logic                             o_irq_oe,
	input  wire logic                        i_timing_ref,
	input  wire logic                        i_frame_sync,
	output logic                             o_frame_start,
	input  wire logic [NUM_HW-1:0]           i_hw_tx_data,
	input  wire logic [NUM_HW-1:0]           i_hw_tx_en,
	output logic      [NUM_HW-1:0]           o_hw_txd,
	output logic      [NUM_HW-1:0]           o_hw_txd_oe,
	input  wire logic                        i_mem_error,
	output logic                             o_bist_active,
	output logic                             o_soft_reset
);
	import tsigc_pkg::*;

	localparam int PIN_W = 5 + ADDR_W + DATA_W;

	// Pin synchroniser, first stage read only by the second
	// Address and data share the stages so they stay aligned with the strobes
	logic [PIN_W-1:0] pin_meta;
	logic [PIN_W-1:0] pin_sync;
	always_ff @(posedge i_sys_clk) begin
		pin_meta <= {i_cs_n, i_rd_n, i_wr_n, i_timing_ref, i_frame_sync, i_addr, i_data};
		pin_sync <= pin_meta;
	end

	wire                    cs_n_s  = pin_sync[PIN_W-1];
	wire                    rd_n_s  = pin_sync[PIN_W-2];
	wire                    wr_n_s  = pin_sync[PIN_W-3];
	wire                    ck_s    = pin_sync[PIN_W-4];
	wire                    fs_s    = pin_sync[PIN_W-5];
	tsigc_bus_req_t         req;
	assign req = pin_sync[ADDR_W+DATA_W-1:0];

	// A strobe counts only while chip select is low
	wire rd_req = !cs_n_s && !rd_n_s;
	wire wr_req = !cs_n_s && !wr_n_s;

	// Host bus handshake, reset only by the pin
	// Ready holds until both strobes are seen high, so one low strobe is one access
	tsigc_bus_state_t bus_state;
	wire bus_idle = (bus_state == BUS_IDLE);
	wire wr_take  = bus_idle && wr_req;
	wire rd_take  = bus_idle && rd_req && !wr_req;
	logic [DATA_W-1:0] rd_mux;

	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) begin
			bus_state <= BUS_IDLE;
			o_rdy     <= 1'b0;
			o_data    <= REG_ZERO;
			o_data_oe <= 1'b0;
		end else begin
			unique case (bus_state)
				BUS_IDLE: if (wr_take || rd_take) begin
					bus_state <= BUS_HOLD;
					o_rdy     <= 1'b1;
					o_data    <= rd_mux;
					o_data_oe <= rd_take;
				end
				BUS_HOLD: if (!rd_req && !wr_req) begin
					bus_state <= BUS_IDLE;
					o_rdy     <= 1'b0;
					o_data_oe <= 1'b0;
				end
			endcase
		end
	end

	// Write decode
	// Writes land on the edge that takes the access; unmapped addresses are ignored
	wire wr_gc  = wr_take && (req.addr == REG_GEN_CMD);
	wire wr_sr  = wr_take && (req.addr == REG_SOFT_RST);
	wire wr_bc  = wr_take && (req.addr == REG_BIST_CMD);
	wire wr_gim = wr_take && (req.addr == REG_GLB_IRQ_MASK);
	wire wr_is  = wr_take && (req.addr == REG_IRQ_STATUS);
	wire wr_im  = wr_take && (req.addr == REG_IRQ_MASK);

	// Software reset bit, cleared only by a zero write or the pin
	// The bus logic stays on the pin reset so the setting write can end its handshake
	logic soft_rst;
	always_ff @(posedge i_sys_clk) begin
		if (!i_nrst) soft_rst <= 1'b0;
		else if (wr_sr) soft_rst <= req.wdata[SR_BIT];
	end
	wire core_nrst = i_nrst && !soft_rst;
	assign o_soft_reset = soft_rst;

	// Control registers, returned to zero by either reset
	// A run write while running is ignored; only a zero write or either reset stops the test
	tsigc_gen_cmd_t gen_cmd;
	logic           run;
	logic           global_irq_enable;
	logic           mask_bc;
	logic           stat_bc;
	logic           bist_done_pulse;
	tsigc_bist_stat_t bist_stat;
	wire  bist_start = wr_bc && req.wdata[BC_RUN] && !run;
	wire  bist_stop  = wr_bc && !req.wdata[BC_RUN];

	always_ff @(posedge i_sys_clk) begin
		if (!core_nrst) begin
			gen_cmd <= '0;
			run     <= 1'b0;
			global_irq_enable     <= 1'b0;
			mask_bc <= 1'b0;
			stat_bc <= 1'b0;
		end else begin
			if (wr_gc) begin
				gen_cmd.interrupt_output_drive_enable <= req.wdata[GC_INTERRUPT_OUTPUT_DRIVE_ENABLE];
				gen_cmd.interrupt_polarity_select  <= req.wdata[GC_INTERRUPT_POLARITY_SELECT];
				gen_cmd.frame_sync_polarity   <= req.wdata[GC_FSP];
				gen_cmd.frame_sync_sample_edge  <= req.wdata[GC_FRAME_SYNC_SAMPLE_EDGE];
				gen_cmd.global_transmit_enable   <= req.wdata[GC_GXE];
			end
			if (wr_bc) run <= req.wdata[BC_RUN];
			if (wr_gim) global_irq_enable <= req.wdata[GIE_BIT];
			if (wr_im) mask_bc <= req.wdata[IRQ_BC];
			// Completion event wins over a same-cycle clear
			if (bist_done_pulse) stat_bc <= 1'b1;
			else if (wr_is && req.wdata[IRQ_BC]) stat_bc <= 1'b0;
		end
	end

	// Self-test sequencer
	// Runs on the core reset so a soft reset also aborts a test in progress
	tsigc_bist #(
		.CYCLES      (BIST_CYCLES)
	) u_bist (
		.i_sys_clk   (i_sys_clk),
		.i_nrst      (core_nrst),
		.i_start     (bist_start),
		.i_stop      (bist_stop),
		.i_mem_error (i_mem_error),
		.o_active    (o_bist_active),
		.o_done_pulse(bist_done_pulse),
		.o_stat      (bist_stat)
	);

	// Read-back, reserved and unmapped bits read zero
	wire [DATA_W-1:0] rd_gc  = {3'b000, gen_cmd.interrupt_output_drive_enable, gen_cmd.interrupt_polarity_select, gen_cmd.frame_sync_polarity,
	                            gen_cmd.frame_sync_sample_edge, gen_cmd.global_transmit_enable};
	wire [DATA_W-1:0] rd_sr  = {7'h00, soft_rst};
	wire [DATA_W-1:0] rd_bc  = {run, bist_stat.done, bist_stat.fail, 5'h00};
	wire [DATA_W-1:0] rd_gim = {7'h00, global_irq_enable};
	wire [DATA_W-1:0] rd_is  = {6'h00, stat_bc, 1'b0};
	wire [DATA_W-1:0] rd_im  = {6'h00, mask_bc, 1'b0};
	assign rd_mux = (req.addr == REG_GEN_CMD)      ? rd_gc  :
	                (req.addr == REG_SOFT_RST)     ? rd_sr  :
	                (req.addr == REG_BIST_CMD)     ? rd_bc  :
	                (req.addr == REG_GLB_IRQ_MASK) ? rd_gim :
	                (req.addr == REG_IRQ_STATUS)   ? rd_is  :
	                (req.addr == REG_IRQ_MASK)     ? rd_im  : REG_ZERO;

	// Interrupt pin level and drive enable
	// One register stage keeps decode glitches off the pin
	wire irq_assert = stat_bc && !mask_bc && global_irq_enable;
	wire irq_level  = gen_cmd.interrupt_polarity_select ? !irq_assert : irq_assert;
	always_ff @(posedge i_sys_clk) begin
		if (!core_nrst) begin
			o_irq    <= 1'b0;
			o_irq_oe <= 1'b0;
		end else begin
			o_irq    <= irq_level;
			o_irq_oe <= gen_cmd.interrupt_output_drive_enable;
		end
	end

	// Frame sync sampling on the selected timing edge
	// The previous level follows the pin in reset, so a high idle level gives no false edge
	logic ck_prev;
	wire  ck_rise   = ck_s && !ck_prev;
	wire  ck_fall   = !ck_s && ck_prev;
	wire  ck_sample = gen_cmd.frame_sync_sample_edge ? ck_rise : ck_fall;
	wire  fs_active = gen_cmd.frame_sync_polarity ? fs_s : !fs_s;
	always_ff @(posedge i_sys_clk) begin
		if (!core_nrst) begin
			ck_prev       <= ck_s;
			o_frame_start <= 1'b0;
		end else begin
			ck_prev       <= ck_s;
			o_frame_start <= ck_sample && fs_active;
		end
	end

	// Per-highway transmit gating
	// Every highway floats until global transmit enable is set, whatever its own enable
	genvar hw;
	generate
		for (hw = 0; hw < NUM_HW; hw++) begin : g_hw
			always_ff @(posedge i_sys_clk) begin
				if (!core_nrst) begin
					o_hw_txd[hw]    <= 1'b0;
					o_hw_txd_oe[hw] <= 1'b0;
				end else begin
					o_hw_txd[hw]    <= i_hw_tx_data[hw];
					o_hw_txd_oe[hw] <= i_hw_tx_en[hw] && gen_cmd.global_transmit_enable;
				end
			end
		end
	endgenerate

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);

	tx_gate_a: assert property (!gen_cmd.global_transmit_enable |=> o_hw_txd_oe == '0)
		else $error("transmit driven while globally disabled");
	irq_drive_a: assert property (!soft_rst ##1 !soft_rst |-> o_irq_oe == $past(gen_cmd.interrupt_output_drive_enable))
		else $error("interrupt drive enable mismatch");
	irq_block_a: assert property (!global_irq_enable && !soft_rst |=> soft_rst || o_irq == $past(gen_cmd.interrupt_polarity_select))
		else $error("interrupt asserted while globally disabled");
	reserved_zero_a: assert property (rd_take && req.addr == REG_BIST_CMD |=> o_data[4:0] == 5'h00)
		else $error("reserved bits read non-zero");
	sr_hold_a: assert property (soft_rst && !(wr_sr && !req.wdata[SR_BIT]) |=> soft_rst)
		else $error("soft reset released without zero write");
	sr_clears_a: assert property (soft_rst |=> gen_cmd == '0 && !run && !stat_bc)
		else $error("registers not held in soft reset");
	sr_ack_a: assert property (wr_sr |=> o_rdy && bus_state == BUS_HOLD)
		else $error("soft reset write not acknowledged");
	done_irq_a: assert property (bist_done_pulse && core_nrst |=> stat_bc)
		else $error("completion status not set");
	frame_hit_a: assert property (o_frame_start |-> $past(gen_cmd.frame_sync_polarity) ? $past(fs_s) : !$past(fs_s))
		else $error("frame start with wrong polarity");

	// Bus handshake: ready holds through the access and drops after release
	rdy_hold_a: assert property (!bus_idle && (rd_req || wr_req) |=> o_rdy)
		else $error("ready dropped while a strobe is still low");
	rdy_drop_a: assert property (!bus_idle && !rd_req && !wr_req |=>
		!o_rdy && !o_data_oe)
		else $error("ready or data drive kept after release");
	wr_no_oe_a: assert property (wr_take |=> !o_data_oe)
		else $error("data bus driven during a write");

	// Read-back of reserved bits and setting of the soft reset bit by a write
	gc_reserved_a: assert property (rd_take && req.addr == REG_GEN_CMD |=>
		o_data[7:5] == 3'h0)
		else $error("reserved command bits read non-zero");
	sr_reserved_a: assert property (rd_take && req.addr == REG_SOFT_RST |=>
		o_data[7:1] == 7'h00)
		else $error("reserved soft reset bits read non-zero");
	sr_set_a: assert property (wr_sr && req.wdata[SR_BIT] |=> soft_rst)
		else $error("soft reset write did not take");

	// Self-test start, stop and completion status
	start_run_a: assert property (bist_start && core_nrst |=> o_bist_active)
		else $error("self-test did not start");
	stop_clear_a: assert property (bist_stop && core_nrst |=>
		!o_bist_active && !bist_stat.done)
		else $error("stop write did not clear the self-test");
	done_set_a: assert property (bist_done_pulse && core_nrst |=> bist_stat.done)
		else $error("done not set at completion");
	stat_keep_a: assert property (stat_bc && core_nrst && !wr_is |=> stat_bc)
		else $error("completion status lost without a clear");

	// Interrupt pin level against mask and polarity
	mask_block_a: assert property (mask_bc && !gen_cmd.interrupt_polarity_select |=> !o_irq)
		else $error("masked completion reached the pin");
	irq_high_a: assert property (irq_assert && !gen_cmd.interrupt_polarity_select && core_nrst |=> o_irq)
		else $error("active high interrupt not asserted");
	irq_low_a: assert property (irq_assert && gen_cmd.interrupt_polarity_select |=> !o_irq)
		else $error("active low interrupt not asserted");

	// Frame start edge choice and transmit pass-through
	edge_sel_a: assert property (o_frame_start |->
		($past(gen_cmd.frame_sync_sample_edge) ? $past(ck_rise) : $past(ck_fall)))
		else $error("frame start on the wrong timing edge");
	tx_pass_a: assert property (gen_cmd.global_transmit_enable && core_nrst |=>
		o_hw_txd_oe == $past(i_hw_tx_en))
		else $error("transmit enable not passed while globally enabled");
endmodule
`default_nettype wire

// File: tb/tsigc_host.sv
// Host processor model driving the register access pins of the block
`timescale 1ns/100ps
`default_nettype none
module tsigc_host (
	input  wire logic                         i_sys_clk,
	input  wire logic                         i_rdy,
	input  wire logic                         i_data_oe,
	input  wire logic [tsigc_pkg::DATA_W-1:0] i_data,
	output logic                              o_cs_n,
	output logic                              o_rd_n,
	output logic                              o_wr_n,
	output logic      [tsigc_pkg::ADDR_W-1:0] o_addr,
	output logic      [tsigc_pkg::DATA_W-1:0] o_data
);
	import tsigc_pkg::*;
	logic hang;
	logic oe_seen;

	// Idle bus at time zero
	initial begin
		hang = 1'b0;
		oe_seen = 1'b0;
		o_cs_n = 1'b1;
		o_rd_n = 1'b1;
		o_wr_n = 1'b1;
		o_addr = '0;
		o_data = 8'hA5;
	end

	// One access: strobes held until ready is seen high, then released
	task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
		int n;
		@(negedge i_sys_clk);
		o_cs_n = 1'b0;
		o_rd_n = w;
		o_wr_n = !w;
		o_addr = a;
		o_data = d;
		n = 0;
		do begin
			@(posedge i_sys_clk);
			n++;
		end while (i_rdy !== 1'b1 && n < 30);
		if (n >= 30) hang = 1'b1;
		q = i_data;
		oe_seen = i_data_oe;
		@(negedge i_sys_clk);
		o_cs_n = 1'b1;
		o_rd_n = 1'b1;
		o_wr_n = 1'b1;
		o_addr = ~a;
		o_data = ~d; // Released lines stop showing the old value
		n = 0;
		do begin
			@(posedge i_sys_clk);
			n++;
		end while (i_rdy !== 1'b0 && n < 30);
		if (n >= 30) hang = 1'b1;
		// Hand back on a falling edge so the caller drives and samples off the clock edge
		@(negedge i_sys_clk);
	endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Register sequence testbench of the global control and self-test block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import tsigc_pkg::*;
	logic              i_sys_clk = 1'b0;
	logic              i_nrst = 1'b0;
	logic              cs_n, rd_n, wr_n;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata;
	logic              data_oe, rdy, irq, irq_oe, frame_start, bist_active, soft_reset;
	logic              ref_clk = 1'b0;
	logic              frame_sync_input = 1'b0;
	logic              mem_error = 1'b0;
	logic [31:0]       tx_data = 32'h5A3C_0FF1;
	logic [31:0]       tx_en = 32'h0000_0000;
	logic [31:0]       txd, txd_oe;
	int                bad_count = 0;
	int                check_count = 0;
	int                fcnt = 0;
	int                n;
	logic [7:0]        q;

	// System clock
	always #4 i_sys_clk = ~i_sys_clk;

	// Frame start pulse counter
	always @(posedge i_sys_clk) if (frame_start === 1'b1) fcnt <= fcnt + 1;

	tsigc_host i_tsigc_host (.i_sys_clk(i_sys_clk), .i_rdy(rdy), .i_data_oe(data_oe), .i_data(rdata),
		.o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_addr(addr), .o_data(wdata));

	tsigc_top #(.NUM_HW(32), .BIST_CYCLES(20)) i_tsigc_top (.i_sys_clk(i_sys_clk),
		.i_nrst(i_nrst), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_addr(addr),
		.i_data(wdata), .o_data(rdata), .o_data_oe(data_oe), .o_rdy(rdy), .o_irq(irq),
		.o_irq_oe(irq_oe), .i_timing_ref(ref_clk), .i_frame_sync(frame_sync_input),
		.o_frame_start(frame_start), .i_hw_tx_data(tx_data), .i_hw_tx_en(tx_en),
		.o_hw_txd(txd), .o_hw_txd_oe(txd_oe), .i_mem_error(mem_error),
		.o_bist_active(bist_active), .o_soft_reset(soft_reset));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		logic [7:0] t;
		i_tsigc_host.xfer(1'b1, a, d, t);
		chk(i_tsigc_host.oe_seen, 1'b0);
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
		logic [7:0] t;
		i_tsigc_host.xfer(1'b0, a, 8'h00, t);
		chk(t, e);
		chk(i_tsigc_host.oe_seen, 1'b1);
	endtask

	task automatic cyc(input int c);
		repeat (c) @(negedge i_sys_clk);
	endtask

	// Edge phase of the timing reference, counting frame starts
	task automatic ref_edge(input logic lvl, input int e);
		cyc(1);
		fcnt = 0;
		ref_clk = lvl;
		cyc(10);
		chk(fcnt, e);
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Watchdog
	initial begin
		#(8 * 30000);
		bad_count++;
		wrap_up();
	end

	// Main sequence
	initial begin
		cyc(10);
		i_nrst = 1'b1;
		cyc(2);
		rd(REG_GEN_CMD, 8'h00);
		rd(REG_SOFT_RST, 8'h00);
		rd(REG_BIST_CMD, 8'h00);
		rd(REG_GLB_IRQ_MASK, 8'h00);
		rd(REG_IRQ_STATUS, 8'h00);
		rd(REG_IRQ_MASK, 8'h00);
		rd(15'h0100, 8'h00);
		chk(irq_oe, 1'b0);
		$display("test reset values done");
		tx_en = 32'hFFFF_FFFF;
		cyc(2);
		chk(txd_oe, 32'h0);
		wr(REG_SOFT_RST, 8'hFE);
		rd(REG_SOFT_RST, 8'h00);
		wr(REG_BIST_CMD, 8'h1F);
		rd(REG_BIST_CMD, 8'h00);
		wr(REG_GEN_CMD, 8'hFF);
		rd(REG_GEN_CMD, 8'h1F);
		chk(irq_oe, 1'b1);
		chk(irq, 1'b1);
		chk(txd_oe, 32'hFFFF_FFFF);
		chk(txd, tx_data);
		wr(REG_GEN_CMD, 8'h00);
		cyc(2);
		chk(irq_oe, 1'b0);
		chk(txd_oe, 32'h0);
		$display("test general command done");
		for (int m = 0; m < 4; m++) begin
			wr(REG_GEN_CMD, 8'(m << 1));
			frame_sync_input = m[1];
			ref_edge(1'b1, m[0]);
			ref_edge(1'b0, !m[0]);
			frame_sync_input = !m[1];
			ref_edge(1'b1, 0);
			ref_edge(1'b0, 0);
		end
		$display("test frame sync done");
		// Host self-test order: run, wait, read result, stop, soft reset
		wr(REG_GLB_IRQ_MASK, 8'h01);
		wr(REG_GEN_CMD, 8'h10);
		wr(REG_BIST_CMD, 8'h80);
		chk(bist_active, 1'b1);
		rd(REG_BIST_CMD, 8'h80);
		n = 0;
		while (irq !== 1'b1 && n < 60) begin
			@(negedge i_sys_clk);
			n++;
		end
		chk(irq, 1'b1);
		rd(REG_BIST_CMD, 8'hC0);
		rd(REG_IRQ_STATUS, 8'h02);
		wr(REG_IRQ_STATUS, 8'h02);
		cyc(2);
		chk(irq, 1'b0);
		wr(REG_BIST_CMD, 8'h00);
		rd(REG_BIST_CMD, 8'h00);
		chk(bist_active, 1'b0);
		wr(REG_IRQ_MASK, 8'h02);
		mem_error = 1'b1;
		wr(REG_BIST_CMD, 8'h80);
		cyc(1);
		mem_error = 1'b0;
		q = 8'h00;
		for (int k = 0; k < 10 && q[6] !== 1'b1; k++)
			i_tsigc_host.xfer(1'b0, REG_BIST_CMD, 8'h00, q);
		chk(q, 8'hE0);
		chk(irq, 1'b0);
		wr(REG_GLB_IRQ_MASK, 8'h00);
		wr(REG_IRQ_MASK, 8'h00);
		cyc(2);
		chk(irq, 1'b0);
		wr(REG_GLB_IRQ_MASK, 8'h01);
		cyc(2);
		chk(irq, 1'b1);
		wr(REG_BIST_CMD, 8'h00);
		wr(REG_BIST_CMD, 8'h80);
		rd(REG_BIST_CMD, 8'h80);
		wr(REG_BIST_CMD, 8'h00);
		$display("test self-test done");
		wr(REG_GEN_CMD, 8'h11);
		wr(REG_SOFT_RST, 8'h01);
		chk(i_tsigc_host.hang, 1'b0);
		chk(soft_reset, 1'b1);
		rd(REG_SOFT_RST, 8'h01);
		rd(REG_GEN_CMD, 8'h00);
		rd(REG_GLB_IRQ_MASK, 8'h00);
		rd(REG_IRQ_STATUS, 8'h00);
		chk(irq_oe, 1'b0);
		wr(REG_GEN_CMD, 8'h1F);
		rd(REG_GEN_CMD, 8'h00);
		wr(REG_SOFT_RST, 8'h00);
		rd(REG_SOFT_RST, 8'h00);
		chk(soft_reset, 1'b0);
		wr(REG_GEN_CMD, 8'h04);
		rd(REG_GEN_CMD, 8'h04);
		chk(i_tsigc_host.hang, 1'b0);
		$display("test soft reset done");
		wrap_up();
	end
endmodule
`default_nettype wire
